//--- common/xdec_pkg.sv
// Purpose: Shared constants and types for the extended indexed decode block
// Assumes: 12-bit data space, 8-bit data, 16-bit instruction words
// Notes:   Wishbone offsets are byte addresses of 32-bit words
package xdec_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int PC_W   = 21;

   // ***************************************************************
   // Opcode fields
   // ***************************************************************
   localparam logic [8:0] OP_MOVE_FIRST = 9'h1d7;  // 1110 1011 1
   localparam logic [3:0] OP_MOVE_SECOND = 4'hf;   // 1111 xxxx x
   localparam logic [7:0] OP_PUSH        = 8'hfa;  // 1111 1010
   localparam logic [7:0] OP_SUB_PTR     = 8'he9;  // 1110 1001
   localparam logic [1:0] SEL_RETURN     = 2'h3;
   localparam logic [1:0] FP_IDX         = 2'h2;

   // ***************************************************************
   // Address remapping
   // ***************************************************************
   localparam logic [7:0] INDEXED_MAX    = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
   localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
   localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;
   localparam logic [11:0] INDIRECT_LO   = 12'hfdb;
   localparam logic [11:0] INDIRECT_HI   = 12'hfef;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_PTR0   = 8'h04;
   localparam logic [7:0] REG_PTR1   = 8'h08;
   localparam logic [7:0] REG_PTR2   = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CTRL_EXT_BIT       = 0;
   localparam int STAT_BUSY_BIT      = 0;
   localparam int STAT_SUPPR_BIT     = 1;
   localparam logic CTRL_EXT_RST     = 1'b0;
   localparam logic [11:0] PTR_RST   = 12'h000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MOVE_READ,
      ST_MOVE_DEST,
      ST_RET_NOP
   } state_t;

   function automatic logic is_indirect(input logic [11:0] a);
      return (a >= INDIRECT_LO) && (a <= INDIRECT_HI);
   endfunction

endpackage

//--- hdl/extended_isa_indexed_decode.sv
// Purpose: Executes indexed move, push literal, pointer subtract and
//          subtract-and-return; remaps short operands of byte/bit ops
// Assumes: Data memory reads are combinational within the read cycle
// Notes:   Pointers and status are reachable over Wishbone
`timescale 1ns/100ps
module extended_isa_indexed_decode
   import xdec_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_clk_en,
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [7:0]        i_wb_adr,
   input  wire logic [3:0]        i_wb_sel,
   input  wire logic [31:0]       i_wb_dat,
   output logic      [31:0]       o_wb_dat,
   output logic                   o_wb_ack,
   input  wire logic              i_instr_valid,
   input  wire logic [15:0]       i_instr,
   output logic                   o_instr_ready,
   output logic      [ADDR_W-1:0] o_mem_addr,
   output logic                   o_mem_rd,
   output logic                   o_mem_wr,
   output logic      [DATA_W-1:0] o_mem_wdata,
   input  wire logic [DATA_W-1:0] i_mem_rdata,
   input  wire logic [PC_W-1:0]   i_stack_top,
   output logic                   o_pc_load,
   output logic      [PC_W-1:0]   o_pc_value,
   input  wire logic              i_std_valid,
   input  wire logic [7:0]        i_std_file,
   input  wire logic              i_std_access,
   input  wire logic              i_std_dest,
   input  wire logic [3:0]        i_bank_select,
   output logic                   o_std_valid,
   output logic      [ADDR_W-1:0] o_std_addr,
   output logic                   o_std_indexed,
   output logic                   o_std_to_wreg
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   state_t                   state_q;
   logic                     ext_q;
   logic                     suppr_q;
   logic [ADDR_W-1:0]        ptr_q [3];
   logic [DATA_W-1:0]        data_q;
   logic                     src_ind_q;
   logic                     take;
   logic                     is_move1;
   logic                     is_move2;
   logic                     is_push;
   logic                     is_sub;
   logic [1:0]               sub_sel;
   logic [ADDR_W-1:0]        fp;
   logic [ADDR_W-1:0]        src_addr;
   logic [ADDR_W-1:0]        dst_addr;
   logic                     hw_we;
   logic [1:0]               hw_idx;
   logic [ADDR_W-1:0]        hw_val;
   logic                     wb_req;
   logic                     wb_wr;
   logic [31:0]              rd_mux;
   logic                     suppr_set;

   // ***************************************************************
   // Instruction decode
   // ***************************************************************
   assign fp            = ptr_q[FP_IDX];
   assign o_instr_ready = (state_q == ST_IDLE) || (state_q == ST_MOVE_DEST);
   assign take          = i_clk_en && i_instr_valid && o_instr_ready;
   assign is_move1      = ext_q && (i_instr[15:7] == OP_MOVE_FIRST);
   assign is_move2      = i_instr[15:12] == OP_MOVE_SECOND;
   assign is_push       = ext_q && (i_instr[15:8] == OP_PUSH);
   assign is_sub        = ext_q && (i_instr[15:8] == OP_SUB_PTR);
   assign sub_sel       = i_instr[7:6];
   // Sums wrap silently in 12 bits
   assign src_addr      = fp + {5'h00, i_instr[6:0]};
   assign dst_addr      = fp + {5'h00, i_instr[6:0]};

   // Single hardware pointer update per cycle
   always_comb begin
      hw_we  = 1'b0;
      hw_idx = FP_IDX;
      hw_val = fp;
      if (take && (state_q == ST_IDLE)) begin
         if (is_push) begin
            hw_we  = 1'b1;
            hw_val = fp - 12'h001;
         end else if (is_sub) begin
            hw_we  = 1'b1;
            // Select 3 always works on the frame pointer
            hw_idx = (sub_sel == SEL_RETURN) ? FP_IDX : sub_sel;
            hw_val = ptr_q[hw_idx] - {6'h00, i_instr[5:0]};
         end
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_q <= ST_IDLE;
      end else if (i_clk_en) begin
         unique case (state_q)
            ST_IDLE: begin
               if (take && is_move1) begin
                  state_q <= ST_MOVE_READ;
               end else if (take && is_sub && (sub_sel == SEL_RETURN)) begin
                  state_q <= ST_RET_NOP;
               end
            end
            ST_MOVE_READ: begin
               state_q <= ST_MOVE_DEST;
            end
            ST_MOVE_DEST: begin
               if (take) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_RET_NOP: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Data memory requests
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_addr  <= 12'h000;
         o_mem_wdata <= 8'h00;
         src_ind_q   <= 1'b0;
      end else if (i_clk_en) begin
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         if (take && (state_q == ST_IDLE) && is_move1) begin
            o_mem_rd   <= 1'b1;
            o_mem_addr <= src_addr;
            src_ind_q  <= is_indirect(src_addr);
         end else if (take && (state_q == ST_IDLE) && is_push) begin
            o_mem_wr    <= 1'b1;
            o_mem_addr  <= fp;
            o_mem_wdata <= i_instr[7:0];
         end else if (take && (state_q == ST_MOVE_DEST) && is_move2) begin
            // A destination in the indirect register range is not written; the move sets the suppress flag instead
            if (!is_indirect(dst_addr)) begin
               o_mem_wr    <= 1'b1;
               o_mem_addr  <= dst_addr;
               o_mem_wdata <= data_q;
            end
         end
      end
   end

   // Source byte, forced to zero for indirect registers
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         data_q <= 8'h00;
      end else if (i_clk_en && (state_q == ST_MOVE_READ)) begin
         data_q <= src_ind_q ? 8'h00 : i_mem_rdata;
      end
   end

   assign suppr_set = take && (state_q == ST_MOVE_DEST) && is_move2 && is_indirect(dst_addr);

   // ***************************************************************
   // Return
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_pc_load  <= 1'b0;
         o_pc_value <= '0;
      end else if (i_clk_en) begin
         o_pc_load <= 1'b0;
         if (take && (state_q == ST_IDLE) && is_sub && (sub_sel == SEL_RETURN)) begin
            o_pc_load  <= 1'b1;
            o_pc_value <= i_stack_top;
         end
      end
   end

   // ***************************************************************
   // Byte and bit operand remapping
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_std_valid   <= 1'b0;
         o_std_addr    <= 12'h000;
         o_std_indexed <= 1'b0;
         o_std_to_wreg <= 1'b0;
      end else if (i_clk_en) begin
         o_std_valid   <= i_std_valid;
         o_std_to_wreg <= !i_std_dest;
         if (ext_q && !i_std_access && (i_std_file <= INDEXED_MAX)) begin
            o_std_indexed <= 1'b1;
            // A zero frame pointer lands on the legacy access locations
            o_std_addr    <= fp + {4'h0, i_std_file};
         end else if (i_std_access) begin
            o_std_indexed <= 1'b0;
            o_std_addr    <= {i_bank_select, i_std_file};
         end else begin
            o_std_indexed <= 1'b0;
            o_std_addr    <= (i_std_file < ACCESS_SPLIT) ?
                             {ACCESS_LO_PAGE, i_std_file} :
                             {ACCESS_HI_PAGE, i_std_file};
         end
      end
   end

   // ***************************************************************
   // Wishbone slave
   // ***************************************************************
   assign wb_req = i_wb_cyc && i_wb_stb;
   assign wb_wr  = wb_req && i_wb_we && o_wb_ack;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_wb_adr)
         REG_CTRL:   rd_mux[CTRL_EXT_BIT] = ext_q;
         REG_PTR0:   rd_mux[ADDR_W-1:0] = ptr_q[0];
         REG_PTR1:   rd_mux[ADDR_W-1:0] = ptr_q[1];
         REG_PTR2:   rd_mux[ADDR_W-1:0] = ptr_q[2];
         REG_STATUS: begin
            rd_mux[STAT_BUSY_BIT]  = state_q != ST_IDLE;
            rd_mux[STAT_SUPPR_BIT] = suppr_q;
         end
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else if (i_clk_en) begin
         o_wb_ack <= wb_req && !o_wb_ack;
         if (wb_req && !o_wb_ack) begin
            o_wb_dat <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ext_q <= CTRL_EXT_RST;
      end else if (i_clk_en && wb_wr && (i_wb_adr == REG_CTRL) && i_wb_sel[0]) begin
         ext_q <= i_wb_dat[CTRL_EXT_BIT];
      end
   end

   // Sticky, set wins over a write-one clear
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         suppr_q <= 1'b0;
      end else if (i_clk_en) begin
         if (suppr_set) begin
            suppr_q <= 1'b1;
         end else if (wb_wr && (i_wb_adr == REG_STATUS) && i_wb_sel[0] &&
                      i_wb_dat[STAT_SUPPR_BIT]) begin
            suppr_q <= 1'b0;
         end
      end
   end

   // Pointers; a hardware update wins over a software write in the same cycle
   for (genvar g = 0; g < 3; g++) begin : g_ptr
      logic [7:0] sw_adr;
      assign sw_adr = REG_PTR0 + 8'(4 * g);
      always_ff @(posedge i_core_clk) begin
         if (i_reset) begin
            ptr_q[g] <= PTR_RST;
         end else if (i_clk_en) begin
            if (hw_we && (hw_idx == 2'(g))) begin
               ptr_q[g] <= hw_val;
            end else if (wb_wr && (i_wb_adr == sw_adr)) begin
               if (i_wb_sel[0]) ptr_q[g][7:0]  <= i_wb_dat[7:0];
               if (i_wb_sel[1]) ptr_q[g][11:8] <= i_wb_dat[11:8];
            end
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   push_write_a: assert property (take && state_q == ST_IDLE && is_push |=>
      o_mem_wr && o_mem_addr == $past(fp) && o_mem_wdata == $past(i_instr[7:0]))
      else $error("push literal wrote wrong place or value");

   push_decr_a: assert property (take && state_q == ST_IDLE && is_push |=>
      ptr_q[2] == 12'($past(fp) - 12'h001))
      else $error("push literal did not decrement frame pointer");

   sub_ptr_a: assert property (
      take && state_q == ST_IDLE && is_sub && sub_sel != SEL_RETURN |=>
      ptr_q[$past(sub_sel)] == 12'($past(ptr_q[sub_sel]) - {6'h00, $past(i_instr[5:0])}) &&
      !o_pc_load)
      else $error("pointer subtract result wrong");

   ret_load_a: assert property (
      take && state_q == ST_IDLE && is_sub && sub_sel == SEL_RETURN |=>
      o_pc_load && o_pc_value == $past(i_stack_top) &&
      ptr_q[2] == 12'($past(fp) - {6'h00, $past(i_instr[5:0])}))
      else $error("subtract and return wrong");

   ret_idle_a: assert property (
      take && state_q == ST_IDLE && is_sub && sub_sel == SEL_RETURN |=>
      !o_instr_ready && !o_mem_wr && !o_mem_rd)
      else $error("subtract and return second cycle not idle");

   move_src_a: assert property (take && state_q == ST_IDLE && is_move1 |=>
      o_mem_rd && !o_instr_ready &&
      o_mem_addr == 12'($past(fp) + {5'h00, $past(i_instr[6:0])}) ##1 o_instr_ready)
      else $error("move source access wrong");

   move_zero_a: assert property (
      i_clk_en && state_q == ST_MOVE_READ && src_ind_q |=>
      data_q == 8'h00)
      else $error("indirect move source not zero");

   move_nop_a: assert property (suppr_set |=> !o_mem_wr && suppr_q)
      else $error("indirect move destination was written");

   std_index_a: assert property (
      i_clk_en && ext_q && !i_std_access && i_std_file <= INDEXED_MAX |=>
      o_std_indexed && o_std_addr == 12'($past(fp) + {4'h0, $past(i_std_file)}))
      else $error("indexed operand not offset from frame pointer");

   std_legacy_a: assert property (i_clk_en && !ext_q && i_std_access |=>
      !o_std_indexed && o_std_addr == {$past(i_bank_select), $past(i_std_file)})
      else $error("banked operand address wrong");

   std_dest_a: assert property (i_clk_en |=> o_std_to_wreg == !$past(i_std_dest))
      else $error("destination select wrong");

   ext_off_a: assert property (take && state_q == ST_IDLE && !ext_q |=>
      !o_mem_wr && !o_mem_rd && !o_pc_load)
      else $error("extended opcode acted while disabled");

   push_c: cover property (take && state_q == ST_IDLE && is_push);
   move_c: cover property (take && state_q == ST_MOVE_DEST && is_move2 ##1 o_mem_wr);
   ret_c:  cover property (o_pc_load ##1 state_q == ST_IDLE);
   index_c: cover property (o_std_valid && o_std_indexed);

endmodule

//--- tb/data_mem_model.sv
// Purpose: Behavioural data memory on the far side of the decode block
// Assumes: Read data is needed combinationally while the read strobe is high
// Notes:   Outside a read the data lines show the inverse of the last read
`timescale 1ns/100ps
module data_mem_model
   import xdec_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_mem_rd,
   input  wire logic              i_mem_wr,
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [DATA_W-1:0] i_mem_wdata,
   output logic      [DATA_W-1:0] o_mem_rdata
);
   logic [DATA_W-1:0] mem [0:4095];
   logic [DATA_W-1:0] last_q;

   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
      last_q = 8'h00;
   end

   // Stale data never looks valid to a late sampler
   always_comb o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : ~last_q;

   always @(posedge i_core_clk) begin
      if (i_mem_rd) last_q <= mem[i_mem_addr];
      if (i_mem_wr) mem[i_mem_addr] <= i_mem_wdata;
   end
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the extended indexed decode block
// Assumes: Clock enable held high throughout
// Notes:   Memory contents are preset and inspected in the memory model
`timescale 1ns/100ps
module tb;
   import xdec_pkg::*;
   logic        core_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, instr_valid, instr_ready;
   logic        mem_rd, mem_wr, pc_load, std_valid, std_access, std_dest;
   logic        std_vo, std_idx, std_wreg;
   logic [7:0]  wb_adr, std_file, mem_wdata, mem_rdata;
   logic [3:0]  wb_sel, bank;
   logic [31:0] wb_wdat, wb_dat, wb_rdat;
   logic [15:0] instr;
   logic [11:0] mem_addr, std_addr;
   logic [20:0] stack_top, pc_value;
   int          error_cnt;
   int          checks_done;

   extended_isa_indexed_decode dut_u (.i_core_clk(core_clk), .i_reset(reset), .i_clk_en(1'b1),
      .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
      .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_dat), .o_wb_ack(wb_ack),
      .i_instr_valid(instr_valid), .i_instr(instr), .o_instr_ready(instr_ready),
      .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata),
      .i_mem_rdata(mem_rdata), .i_stack_top(stack_top), .o_pc_load(pc_load),
      .o_pc_value(pc_value), .i_std_valid(std_valid), .i_std_file(std_file),
      .i_std_access(std_access), .i_std_dest(std_dest), .i_bank_select(bank),
      .o_std_valid(std_vo), .o_std_addr(std_addr), .o_std_indexed(std_idx),
      .o_std_to_wreg(std_wreg));

   data_mem_model mem_u (.i_core_clk(core_clk), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr),
      .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic results;
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic hang;
      error_cnt++;
      results();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50) hang();
      wb_rdat = wb_dat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // Leaves the caller at the middle of the cycle that shows the effects
   task automatic issue(input logic [15:0] w);
      int n;
      n = 0;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr <= w;
      @(negedge core_clk);
      while (instr_ready !== 1'b1 && n < 50) begin
         n++;
         @(negedge core_clk);
      end
      if (n >= 50) hang();
      @(posedge core_clk);
      instr_valid <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic stdop(input logic a, input logic [7:0] f, input logic d,
                        input logic [11:0] ea, input logic ei);
      @(posedge core_clk);
      std_valid <= 1'b1;
      std_access <= a;
      std_file <= f;
      std_dest <= d;
      @(posedge core_clk);
      std_valid <= 1'b0;
      @(negedge core_clk);
      chk({17'h0, std_vo, std_idx, std_wreg, std_addr}, {17'h0, 1'b1, ei, ~d, ea});
   endtask

   task automatic rdptr(input logic [7:0] a, input logic [11:0] e);
      wb(1'b0, a, 32'h0);
      chk({20'h0, wb_rdat[11:0]}, {20'h0, e});
   endtask

   initial begin
      #40000;
      hang();
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      {reset, wb_cyc, wb_stb, wb_we, instr_valid, std_valid, std_access, std_dest} = 8'h80;
      {wb_adr, std_file, bank, instr, wb_wdat} = '0;
      wb_sel = 4'h3;
      stack_top = 21'h12345;
      error_cnt = 0;
      checks_done = 0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0);
      chk(wb_rdat, 32'h0);
      rdptr(REG_PTR2, PTR_RST);
      wb(1'b0, 8'h14, 32'h0);
      chk(wb_rdat, 32'h0);
      wb(1'b1, REG_PTR2, 32'h1ec);
      issue({OP_PUSH, 8'h08});
      chk({31'h0, mem_wr}, 32'h0);
      rdptr(REG_PTR2, 12'h1ec);
      bank <= 4'h3;
      stdop(1'b0, 8'h20, 1'b1, 12'h020, 1'b0);
      stdop(1'b0, 8'h90, 1'b0, 12'hf90, 1'b0);
      stdop(1'b1, 8'h20, 1'b1, 12'h320, 1'b0);
      wb(1'b1, REG_CTRL, 32'h1);
      issue({OP_PUSH, 8'h08});
      chk({11'h0, mem_wr, mem_addr, mem_wdata}, {11'h0, 1'b1, 12'h1ec, 8'h08});
      rdptr(REG_PTR2, 12'h1eb);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, REG_PTR0 + {i[5:0], 2'b00}, 32'h3ff);
         issue({OP_SUB_PTR, i[1:0], 6'h23});
         rdptr(REG_PTR0 + {i[5:0], 2'b00}, 12'h3dc);
      end
      wb(1'b1, REG_PTR1, 32'h5);
      issue({OP_SUB_PTR, 2'h1, 6'h3f});
      rdptr(REG_PTR1, 12'hfc6);
      wb(1'b1, REG_PTR2, 32'h3ff);
      issue({OP_SUB_PTR, SEL_RETURN, 6'h23});
      chk({9'h0, pc_load, instr_ready, pc_value}, {9'h0, 2'b10, 21'h12345});
      @(negedge core_clk);
      chk({30'h0, pc_load, instr_ready}, 32'h1);
      rdptr(REG_PTR2, 12'h3dc);
      rdptr(REG_PTR0, 12'h3dc);
      wb(1'b1, REG_PTR2, 32'h80);
      mem_u.mem[12'h085] = 8'h33;
      issue({OP_MOVE_FIRST, 7'h05});
      chk({19'h0, mem_rd, mem_addr}, {19'h0, 1'b1, 12'h085});
      issue({OP_MOVE_SECOND, 5'h1f, 7'h06});
      chk({11'h0, mem_wr, mem_addr, mem_wdata}, {11'h0, 1'b1, 12'h086, 8'h33});
      wb(1'b1, REG_PTR2, 32'hf80);
      mem_u.mem[12'hfdb] = 8'h5a;
      mem_u.mem[12'hf85] = 8'h77;
      mem_u.mem[12'hfef] = 8'h44;
      issue({OP_MOVE_FIRST, 7'h5b});
      issue({OP_MOVE_SECOND, 5'h00, 7'h7f});
      chk({11'h0, mem_wr, mem_addr, mem_wdata}, {11'h0, 1'b1, 12'hfff, 8'h00});
      issue({OP_MOVE_FIRST, 7'h05});
      issue({OP_MOVE_SECOND, 5'h00, 7'h6f});
      chk({31'h0, mem_wr}, 32'h0);
      chk({24'h0, mem_u.mem[12'hfef]}, 32'h44);
      wb(1'b0, REG_STATUS, 32'h0);
      chk({31'h0, wb_rdat[STAT_SUPPR_BIT]}, 32'h1);
      wb(1'b1, REG_PTR2, 32'hfc0);
      issue({OP_MOVE_FIRST, 7'h7f});
      chk({19'h0, mem_rd, mem_addr}, {19'h0, 1'b1, 12'h03f});
      issue({OP_MOVE_SECOND, 5'h00, 7'h00});
      chk({19'h0, mem_wr, mem_addr}, {19'h0, 1'b1, 12'hfc0});
      wb(1'b1, REG_PTR2, 32'ha00);
      stdop(1'b0, 8'h5f, 1'b0, 12'ha5f, 1'b1);
      stdop(1'b0, 8'h60, 1'b1, 12'h060, 1'b0);
      stdop(1'b0, 8'h2c, 1'b1, 12'ha2c, 1'b1);
      stdop(1'b1, 8'h2c, 1'b0, 12'h32c, 1'b0);
      wb(1'b1, REG_PTR2, 32'h0);
      stdop(1'b0, 8'h10, 1'b1, 12'h010, 1'b1);
      results();
   end
endmodule
